// >>> verification/dcpwm_load.sv
// Load model seen by the PWM pins of the dual channel timer.
`timescale 1ns/1ps
module dcpwm_load (
    input wire logic [5:0] pwm_out, // Driven pin values.
    input wire logic [5:0] pwm_oe_n, // Drive enables, active low.
    output logic [5:0] pin_level // Level the load sees.
);
    // ==========================================================
    // Pin resolution
    // The loads hold weak pull-downs, so a released pin reads low and
    // never keeps the last driven value.
    // released pins low
    assign pin_level = pwm_out & ~pwm_oe_n;
endmodule

// >>> verification/dcpwm_top_bench.sv
// Self-checking testbench for the dual channel PWM timer.
`timescale 1ns/1ps
module dcpwm_top_bench;
    // ==========================================================
    // Signals
    logic hclk, hresetn, hsel, hwrite, trigger_in;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, irq;
    logic [5:0] pwm_out, pwm_oe_n, pin_level;
    logic [1:0] event_link_unit;
    logic [7:0] sig;
    int miscompares = 0;
    int num_checks = 0;
    logic [31:0] exp_q[$], obs_q[$];
    string nm_q[$];
    event obs_ev;
    logic [7:0] rst_a [8] = '{dcpwm_pkg::ADDR_PIN_EN,
        dcpwm_pkg::ADDR_ACT_LVL, dcpwm_pkg::ADDR_INIT_LVL,
        dcpwm_pkg::ADDR_PRESCALE, dcpwm_pkg::ADDR_INT_MASK,
        dcpwm_pkg::ADDR_PER0, dcpwm_pkg::ADDR_DUTY_FIRST, 8'h48};
    logic [31:0] rst_v [8] = '{32'h0, 32'h3F, 32'h0, 32'h0, 32'h0,
        32'hFFFF, 32'h0, 32'h0};
    assign sig = {event_link_unit, pin_level};
    dcpwm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in),
        .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
        .event_link_unit(event_link_unit), .irq(irq));
    dcpwm_load load (.pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
        .pin_level(pin_level));
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ==========================================================
    // Checking
    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] v,
                         input logic [31:0] e);
        num_checks++;
        if (v !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, v);
            miscompares++;
        end
    endtask
    // The note goes on the queue before the result is announced.
    task automatic expect_eq(input string nm, input logic [31:0] v,
                             input logic [31:0] e);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        obs_q.push_back(v);
        ->obs_ev;
    endtask
    // Draining in a loop keeps two results of one time step apart.
    always @(obs_ev)
    begin
        while (obs_q.size() > 0)
            check(nm_q.pop_front(), obs_q.pop_front(), exp_q.pop_front());
    end
    task automatic fail_wait();
        miscompares++;
        complete_run();
    endtask
    // ==========================================================
    // Bus master
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 64)
                fail_wait();
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        expect_eq(nm, x, e);
        expect_eq("hresp", {31'h0, hresp}, 32'h0);
    endtask
    // Length of the next whole run of level l on bit i of sig.
    task automatic run_len(input int i, input logic l, output int len);
        int n;
        n = 0;
        len = 0;
        while (sig[i] === l && n < 900)
        begin
            @(posedge hclk);
            n++;
        end
        while (sig[i] !== l && n < 900)
        begin
            @(posedge hclk);
            n++;
        end
        while (sig[i] === l && n < 900)
        begin
            @(posedge hclk);
            n++;
            len++;
        end
        if (n >= 900)
            fail_wait();
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        logic [31:0] v, m, n, n2, x, hold;
        int len;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        trigger_in = 1'b0;
        void'($urandom(60766));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        expect_eq("oe_n", {26'h0, pwm_oe_n}, 32'h3F);
        for (int k = 0; k < 8; k++)
            rd_chk("reset", rst_a[k], rst_v[k]);
        v = $urandom & 32'h0000FFFF;
        wr(dcpwm_pkg::ADDR_CNT0, v);
        rd_chk("cnt0", dcpwm_pkg::ADDR_CNT0, v);
        rd_chk("cnt1", dcpwm_pkg::ADDR_CNT1, 32'h0);
        wr(dcpwm_pkg::ADDR_CTRL, 32'h10);
        wr(dcpwm_pkg::ADDR_CNT1, ~v & 32'h0000FFFF);
        rd_chk("cnt0", dcpwm_pkg::ADDR_CNT0, ~v & 32'h0000FFFF);
        rd_chk("cnt1", dcpwm_pkg::ADDR_CNT1, ~v & 32'h0000FFFF);
        wr(dcpwm_pkg::ADDR_CNT0, 32'h0);
        v = $urandom & 32'h3F;
        wr(dcpwm_pkg::ADDR_INIT_LVL, v);
        wr(dcpwm_pkg::ADDR_PIN_EN, 32'h03);
        repeat (3) @(posedge hclk);
        expect_eq("init", {26'h0, pwm_out}, v);
        expect_eq("oe_n", {26'h0, pwm_oe_n}, 32'h3C);
        m = 4 + ($urandom % 8);
        n = $urandom % m;
        n2 = $urandom % m;
        wr(dcpwm_pkg::ADDR_PER0, m);
        wr(dcpwm_pkg::ADDR_DUTY_FIRST, n);
        wr(dcpwm_pkg::ADDR_DUTY_FIRST + 8'h04, n2);
        wr(dcpwm_pkg::ADDR_ACT_LVL, 32'h3D);
        wr(dcpwm_pkg::ADDR_CTRL, 32'h05);
        run_len(0, 1'b1, len);
        expect_eq("active", len, m - n);
        run_len(0, 1'b0, len);
        expect_eq("inactive", len, n + 1);
        run_len(1, 1'b0, len);
        expect_eq("low_act", len, m - n2);
        run_len(6, 1'b0, len);
        expect_eq("period", len + 1, m + 1);
        bus(1'b0, dcpwm_pkg::ADDR_CNT0, 32'h0, x);
        expect_eq("cnt_run", {31'h0, x <= m}, 32'h1);
        wr(dcpwm_pkg::ADDR_CTRL, 32'h04);
        repeat (2) @(posedge hclk);
        hold = {26'h0, pwm_out};
        repeat (3 * m) @(posedge hclk);
        expect_eq("hold", {26'h0, pwm_out}, hold);
        wr(dcpwm_pkg::ADDR_INT_MASK, 32'h4);
        trigger_in <= 1'b1;
        repeat (6) @(posedge hclk);
        expect_eq("oe_trig", {26'h0, pwm_oe_n}, 32'h3F);
        expect_eq("irq", {31'h0, irq}, 32'h1);
        rd_chk("stat", dcpwm_pkg::ADDR_INT_STAT, 32'h5);
        wr(dcpwm_pkg::ADDR_INT_STAT, 32'h5);
        repeat (2) @(posedge hclk);
        expect_eq("irq_clr", {31'h0, irq}, 32'h0);
        trigger_in <= 1'b0;
        repeat (4) @(posedge hclk);
        expect_eq("oe_back", {26'h0, pwm_oe_n}, 32'h3C);
        wr(dcpwm_pkg::ADDR_INT_MASK, 32'h0);
        trigger_in <= 1'b1;
        repeat (6) @(posedge hclk);
        expect_eq("irq_mask", {31'h0, irq}, 32'h0);
        rd_chk("stat", dcpwm_pkg::ADDR_INT_STAT, 32'h4);
        // Channel 1 on a slower count clock, then the hardware stop.
        trigger_in <= 1'b0;
        v = 1 + ($urandom % 3);
        wr(dcpwm_pkg::ADDR_PRESCALE, v);
        wr(dcpwm_pkg::ADDR_PER1, m);
        wr(dcpwm_pkg::ADDR_DUTY_FIRST + 8'h0C, n);
        wr(dcpwm_pkg::ADDR_PIN_EN, 32'h0B);
        wr(dcpwm_pkg::ADDR_CTRL, 32'h0A);
        run_len(3, 1'b1, len);
        expect_eq("act_ch1", len, (m - n) * (v + 1));
        run_len(7, 1'b0, len);
        expect_eq("period_ch1", len + 1, (m + 1) * (v + 1));
        wr(dcpwm_pkg::ADDR_CTRL, 32'h02);
        repeat (100) @(posedge hclk);
        rd_chk("ctrl_stop", dcpwm_pkg::ADDR_CTRL, 32'h0);
        rd_chk("cnt1_stop", dcpwm_pkg::ADDR_CNT1, 32'h0);
        @(posedge hclk);
        complete_run();
    end
endmodule

// >>> verilog/dcpwm_pkg.sv
// Constants shared by the dual channel PWM timer.
package dcpwm_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PIN_EN = 8'h04;
    localparam logic [7:0] ADDR_ACT_LVL = 8'h08;
    localparam logic [7:0] ADDR_INIT_LVL = 8'h0C;
    localparam logic [7:0] ADDR_INT_STAT = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;
    localparam logic [7:0] ADDR_PRESCALE = 8'h18;
    localparam logic [7:0] ADDR_CNT0 = 8'h20;
    localparam logic [7:0] ADDR_CNT1 = 8'h24;
    localparam logic [7:0] ADDR_PER0 = 8'h28;
    localparam logic [7:0] ADDR_PER1 = 8'h2C;
    localparam logic [7:0] ADDR_DUTY_FIRST = 8'h30;
    localparam logic [7:0] ADDR_DUTY_LAST = 8'h44;
    // ==========================================================
    // Field positions
    localparam int CTRL_START_LSB = 0;
    localparam int CTRL_STOPSEL_LSB = 2;
    localparam int CTRL_SYNC_BIT = 4;
    localparam int STAT_TRIG_BIT = 2;
    localparam int NUM_CH = 2;
    localparam int NUM_PIN = 6;
    localparam int NUM_STAT = 3;
    // ==========================================================
    // Reset values
    localparam logic [7:0] PRESCALE_RST = 8'h00;
    localparam logic [5:0] PIN_EN_RST = 6'h00;
    localparam logic [5:0] ACT_LVL_RST = 6'h3F;
    localparam logic [5:0] INIT_LVL_RST = 6'h00;
endpackage

// >>> verilog/dcpwm_top.sv
// Dual channel PWM timer with an AHB-Lite register slave.
`timescale 1ns/1ps
module dcpwm_top #(
    parameter int CW = 16
) (
    input wire logic hclk, // System clock.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // Slave select.
    input wire logic [31:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write when high.
    input wire logic [2:0] hsize, // Transfer size.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    output logic [31:0] hrdata, // Read data.
    output logic hreadyout, // Slave ready.
    output logic hresp, // Always OKAY.
    input wire logic trigger_in, // External output disable trigger.
    output logic [5:0] pwm_out, // Pins B,C,D of ch0 then of ch1.
    output logic [5:0] pwm_oe_n, // Pin drive enable, active low.
    output logic [1:0] event_link_unit, // Period match event pulses.
    output logic irq // Level interrupt.
);
    // ==========================================================
    // Helpers
    function automatic logic [CW-1:0] cnt_next(
        input logic [CW-1:0] c,
        input logic [CW-1:0] p
    );
        if (c == p)
            return '0;
        return CW'(c + 1'b1);
    endfunction

    function automatic logic is_duty(input logic [7:0] a);
        return (a >= dcpwm_pkg::ADDR_DUTY_FIRST) &&
            (a <= dcpwm_pkg::ADDR_DUTY_LAST) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] duty_idx(input logic [7:0] a);
        logic [7:0] off;
        off = 8'(a - dcpwm_pkg::ADDR_DUTY_FIRST);
        return off[4:2];
    endfunction

    // ==========================================================
    // State
    logic [1:0] start_q;
    logic [1:0] stopsel_q;
    logic sync_q;
    logic [5:0] pin_en_q;
    logic [5:0] act_q;
    logic [5:0] init_q;
    logic [5:0] lvl_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic [7:0] presc_q;
    logic [7:0] div_q;
    logic tick_q;
    logic [CW-1:0] cnt_q [2];
    logic [CW-1:0] per_q [2];
    logic [CW-1:0] duty_q [6];
    logic [CW-1:0] nxt [2];
    logic [1:0] seen_q;
    logic trig_m_q;
    logic trig_s_q;
    logic trig_d_q;
    logic wr_q;
    logic [7:0] waddr_q;
    logic [31:0] rd_data;
    logic ap;
    logic wr_ctrl;
    logic wr_cnt_any;
    logic [1:0] match;
    logic [1:0] start_set;

    assign ap = hsel && hready && htrans[1];
    assign wr_ctrl = wr_q && (waddr_q == dcpwm_pkg::ADDR_CTRL);
    assign wr_cnt_any = wr_q && ((waddr_q == dcpwm_pkg::ADDR_CNT0) ||
        (waddr_q == dcpwm_pkg::ADDR_CNT1));

    always_comb
    begin
        for (int i = 0; i < dcpwm_pkg::NUM_CH; i++)
        begin
            nxt[i] = cnt_next(cnt_q[i], per_q[i]);
            match[i] = tick_q && start_q[i] && (cnt_q[i] == per_q[i]);
            start_set[i] = wr_ctrl && hwdata[dcpwm_pkg::CTRL_START_LSB + i]
                && !start_q[i];
        end
    end

    // ==========================================================
    // Bus slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            waddr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_q <= ap && hwrite;
            if (ap)
                waddr_q <= haddr[7:0];
            if (ap && !hwrite)
                hrdata <= rd_data;
        end
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (haddr[7:0] == dcpwm_pkg::ADDR_CTRL)
            rd_data[4:0] = {sync_q, stopsel_q, start_q};
        else if (haddr[7:0] == dcpwm_pkg::ADDR_PIN_EN)
            rd_data[5:0] = pin_en_q;
        else if (haddr[7:0] == dcpwm_pkg::ADDR_ACT_LVL)
            rd_data[5:0] = act_q;
        else if (haddr[7:0] == dcpwm_pkg::ADDR_INIT_LVL)
            rd_data[5:0] = init_q;
        else if (haddr[7:0] == dcpwm_pkg::ADDR_INT_STAT)
            rd_data[2:0] = stat_q;
        else if (haddr[7:0] == dcpwm_pkg::ADDR_INT_MASK)
            rd_data[2:0] = mask_q;
        else if (haddr[7:0] == dcpwm_pkg::ADDR_PRESCALE)
            rd_data[7:0] = presc_q;
        else if (haddr[7:0] == dcpwm_pkg::ADDR_CNT0)
            rd_data[CW-1:0] = cnt_q[0];
        else if (haddr[7:0] == dcpwm_pkg::ADDR_CNT1)
            rd_data[CW-1:0] = cnt_q[1];
        else if (haddr[7:0] == dcpwm_pkg::ADDR_PER0)
            rd_data[CW-1:0] = per_q[0];
        else if (haddr[7:0] == dcpwm_pkg::ADDR_PER1)
            rd_data[CW-1:0] = per_q[1];
        else if (is_duty(haddr[7:0]))
            rd_data[CW-1:0] = duty_q[duty_idx(haddr[7:0])];
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stopsel_q <= 2'h0;
            sync_q <= 1'b0;
            pin_en_q <= dcpwm_pkg::PIN_EN_RST;
            act_q <= dcpwm_pkg::ACT_LVL_RST;
            init_q <= dcpwm_pkg::INIT_LVL_RST;
            mask_q <= 3'h0;
            presc_q <= dcpwm_pkg::PRESCALE_RST;
            per_q <= '{default: '1};
            duty_q <= '{default: '0};
        end
        else if (wr_q)
        begin
            if (waddr_q == dcpwm_pkg::ADDR_CTRL)
            begin
                stopsel_q <= hwdata[dcpwm_pkg::CTRL_STOPSEL_LSB +: 2];
                sync_q <= hwdata[dcpwm_pkg::CTRL_SYNC_BIT];
            end
            else if (waddr_q == dcpwm_pkg::ADDR_PIN_EN)
                pin_en_q <= hwdata[5:0];
            else if (waddr_q == dcpwm_pkg::ADDR_ACT_LVL)
                act_q <= hwdata[5:0];
            else if (waddr_q == dcpwm_pkg::ADDR_INIT_LVL)
                init_q <= hwdata[5:0];
            else if (waddr_q == dcpwm_pkg::ADDR_INT_MASK)
                mask_q <= hwdata[2:0];
            else if (waddr_q == dcpwm_pkg::ADDR_PRESCALE)
                presc_q <= hwdata[7:0];
            else if (waddr_q == dcpwm_pkg::ADDR_PER0)
                per_q[0] <= hwdata[CW-1:0];
            else if (waddr_q == dcpwm_pkg::ADDR_PER1)
                per_q[1] <= hwdata[CW-1:0];
            else if (is_duty(waddr_q))
                duty_q[duty_idx(waddr_q)] <= hwdata[CW-1:0];
        end
    end

    // ==========================================================
    // Count clock enable
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end
        else if (div_q >= presc_q)
        begin
            div_q <= 8'h00;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q <= 8'(div_q + 1'b1);
            tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // Start bits and counters
    // A software write to the control word wins over the hardware stop,
    // so a restart issued at the final match is never lost.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_q <= 2'h0;
            seen_q <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < dcpwm_pkg::NUM_CH; i++)
            begin
                if (wr_ctrl)
                    start_q[i] <= hwdata[dcpwm_pkg::CTRL_START_LSB + i];
                else if (match[i] && !stopsel_q[i])
                    start_q[i] <= 1'b0;
                if (start_set[i])
                    seen_q[i] <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= '{default: '0};
        else
        begin
            for (int i = 0; i < dcpwm_pkg::NUM_CH; i++)
            begin
                if (wr_q && ((sync_q && wr_cnt_any) || (waddr_q ==
                    (i == 0 ? dcpwm_pkg::ADDR_CNT0 : dcpwm_pkg::ADDR_CNT1))))
                    cnt_q[i] <= hwdata[CW-1:0];
                else if (tick_q && start_q[i])
                    cnt_q[i] <= nxt[i];
            end
        end
    end

    // ==========================================================
    // Waveform levels, 1 meaning active
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lvl_q <= 6'h00;
        else
        begin
            for (int k = 0; k < dcpwm_pkg::NUM_PIN; k++)
            begin
                if (tick_q && start_q[k / 3])
                    lvl_q[k] <= nxt[k / 3] > duty_q[k];
                else if (start_set[k / 3])
                    lvl_q[k] <= cnt_q[k / 3] > duty_q[k];
            end
        end
    end

    // ==========================================================
    // Trigger synchroniser and pins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trig_m_q <= 1'b0;
            trig_s_q <= 1'b0;
            trig_d_q <= 1'b0;
        end
        else
        begin
            trig_m_q <= trigger_in;
            trig_s_q <= trig_m_q;
            trig_d_q <= trig_s_q;
        end
    end

    // Pin A of each channel has no PWM function, so no port exists.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_out <= 6'h00;
            pwm_oe_n <= 6'h3F;
        end
        else
        begin
            for (int k = 0; k < dcpwm_pkg::NUM_PIN; k++)
            begin
                pwm_out[k] <= seen_q[k / 3] ? (lvl_q[k] ~^ act_q[k]) :
                    init_q[k];
                pwm_oe_n[k] <= !(pin_en_q[k] && !trig_s_q);
            end
        end
    end

    // ==========================================================
    // Events and interrupt
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            event_link_unit <= 2'h0;
            stat_q <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            event_link_unit <= match;
            // A new event in the clearing cycle stays set.
            stat_q <= (stat_q & ~((wr_q && (waddr_q ==
                dcpwm_pkg::ADDR_INT_STAT)) ? hwdata[2:0] : 3'h0)) |
                {trig_s_q && !trig_d_q, match};
            irq <= |(stat_q & mask_q);
        end
    end

    // ==========================================================
    // Checks
    property p_cnt_read;
        @(posedge hclk) disable iff (!hresetn)
        (ap && !hwrite && haddr[7:0] == dcpwm_pkg::ADDR_CNT1)
            |=> hrdata[CW-1:0] == $past(cnt_q[1]);
    endproperty
    a_cnt_read: assert property (p_cnt_read)
        else $error("counter read mismatch");

    property p_indep;
        @(posedge hclk) disable iff (!hresetn)
        (wr_q && !sync_q && waddr_q == dcpwm_pkg::ADDR_CNT0 &&
            !(tick_q && start_q[1])) |=> $stable(cnt_q[1]);
    endproperty
    a_indep: assert property (p_indep)
        else $error("unsynced write disturbed other counter");

    property p_sync_load;
        @(posedge hclk) disable iff (!hresetn)
        (wr_q && sync_q && waddr_q == dcpwm_pkg::ADDR_CNT0)
            |=> cnt_q[1] == $past(hwdata[CW-1:0]) && cnt_q[0] == cnt_q[1];
    endproperty
    a_sync_load: assert property (p_sync_load)
        else $error("synced write did not load both");

    property p_trig;
        @(posedge hclk) disable iff (!hresetn)
        trig_s_q |=> pwm_oe_n == 6'h3F;
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger did not disable outputs");

    property p_pin_en;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> ((~pwm_oe_n) & ~$past(pin_en_q)) == 6'h00;
    endproperty
    a_pin_en: assert property (p_pin_en)
        else $error("disabled pin driven");

    property p_active;
        @(posedge hclk) disable iff (!hresetn)
        seen_q[0] |=> pwm_out[0] == ($past(lvl_q[0]) ~^ $past(act_q[0]));
    endproperty
    a_active: assert property (p_active)
        else $error("active level wrong");

    property p_init;
        @(posedge hclk) disable iff (!hresetn)
        !seen_q[1] |=> pwm_out[5:3] == $past(init_q[5:3]);
    endproperty
    a_init: assert property (p_init)
        else $error("initial level wrong");

    property p_evt;
        @(posedge hclk) disable iff (!hresetn)
        (tick_q && start_q[0] && cnt_q[0] == per_q[0])
            |=> event_link_unit[0] ##1 !event_link_unit[0] || tick_q;
    endproperty
    a_evt: assert property (p_evt)
        else $error("event pulse missing");

    property p_wrap;
        @(posedge hclk) disable iff (!hresetn)
        (tick_q && start_q[0] && cnt_q[0] == per_q[0] && !wr_cnt_any)
            |=> cnt_q[0] == '0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not clear on period match");

    property p_duty;
        @(posedge hclk) disable iff (!hresetn)
        (tick_q && start_q[1] && !wr_q)
            |=> lvl_q[3] == (cnt_q[1] > duty_q[3]);
    endproperty
    a_duty: assert property (p_duty)
        else $error("duty level wrong");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        (!start_q[0] && !wr_ctrl) |=> $stable(lvl_q[2:0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("level changed while stopped");
endmodule
